//--- shared/rtcac_pkg.sv
// constants of the clock value, alarm value and calibration block
// assumes a classic wishbone master with 32-bit data, byte addresses
package rtcac_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [4:0] OFF_TIME_MS = 5'h00;
  localparam logic [4:0] OFF_ALM_MD = 5'h04;
  localparam logic [4:0] OFF_ALM_WH = 5'h08;
  localparam logic [4:0] OFF_ALM_MS = 5'h0C;
  localparam logic [4:0] OFF_CTRL = 5'h10;

  // ************************************************************
  // implemented bits and reset values
  // ************************************************************
  localparam logic [15:0] MASK_MS = 16'h7F7F;
  localparam logic [15:0] MASK_MD = 16'h1F3F;
  localparam logic [15:0] MASK_WH = 16'h073F;
  localparam logic [15:0] MASK_CTRL = 16'h21FF;
  localparam logic [15:0] RST_VALUE = 16'h0000;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int MIN_TEN_LSB = 12;
  localparam int MIN_ONE_LSB = 8;
  localparam int SEC_TEN_LSB = 4;
  localparam int SEC_ONE_LSB = 0;
  localparam int CTRL_CAL_LSB = 0;
  localparam int CTRL_TIMER_ON = 8;
  localparam int CTRL_WR_EN = 13;

  // ************************************************************
  // digit limits and timing
  // ************************************************************
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [3:0] BCD_FIVE = 4'h5;
  localparam int TICK_HZ = 32768;
  localparam int CAL_STEP_SHIFT = 2;

endpackage

//--- design/rtcac_core.sv
// minutes/seconds time register, alarm value registers and calibration
// assumes tick_i is the 32.768 kHz timekeeping clock from a pin and a
// classic wishbone master on clk_i
//
// Overview of operation
// - minute tens in bits 14-12, minute ones in bits 11-8, BCD.
// - second tens in bits 6-4, second ones in bits 3-0, BCD.
// - alarm month tens in bit 12, month ones in bits 11-8.
// - alarm day tens in bits 5-4, day ones in bits 3-0.
// - alarm weekday digit 0 to 6 in bits 10-8.
// - alarm hour tens in bits 5-4, hour ones in bits 3-0.
// - unimplemented bits read zero and ignore writes.
// - alarm month/day and weekday/hours writable only with write enable.
// - once a minute, signed calibration times four corrects the count.
// - each calibration step is four timekeeping pulses per minute.
// - negative calibration adds pulses for a fast oscillator.
`timescale 1ns/10ps
module rtcac_core #(
  parameter int PRESCALE = rtcac_pkg::TICK_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tick_i,
  output logic sec_pulse_o,
  output logic cal_applied_o
);

  // cal takes up to 127*4 off a second, which must stay positive
  initial begin
    if (PRESCALE < 1024 || PRESCALE > 65536) begin
      $error("rtcac_core: PRESCALE out of range");
    end
  end

  localparam logic [16:0] PRE_M1 = 17'(PRESCALE - 1);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel,
                                        input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (sel[0]) begin
      v[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      v[15:8] = wd[15:8];
    end
    merge = v & mask;
  endfunction

  // returns carry and next digit
  function automatic logic [4:0] bcd_inc(input logic [3:0] d,
                                         input logic [3:0] max);
    if (d >= max) begin
      bcd_inc = {1'b1, 4'h0};
    end else begin
      bcd_inc = {1'b0, d + 4'h1};
    end
  endfunction

  // ************************************************************
  // tick synchroniser
  // ************************************************************
  logic tick_s1_ff, tick_s2_ff, tick_s3_ff;
  logic tick_en;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_s1_ff <= 1'b0;
      tick_s2_ff <= 1'b0;
      tick_s3_ff <= 1'b0;
    end else begin
      tick_s1_ff <= tick_i;
      tick_s2_ff <= tick_s1_ff;
      tick_s3_ff <= tick_s2_ff;
    end
  end

  assign tick_en = tick_s2_ff & ~tick_s3_ff;

  // ************************************************************
  // wishbone slave and registers
  // ************************************************************
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [15:0] time_ms_ff, nxt_time_ms;
  logic [15:0] alm_md_ff, nxt_alm_md;
  logic [15:0] alm_wh_ff, nxt_alm_wh;
  logic [15:0] alm_ms_ff, nxt_alm_ms;
  logic [15:0] ctrl_ff, nxt_ctrl;
  logic [16:0] pre_ff, nxt_pre;
  logic sec_ff, nxt_sec;
  logic cal_ff, nxt_cal;
  logic req, wr_fire, wr_en, timer_on, sec_end, min_end;
  logic [4:0] adr;
  logic [7:0] cal;
  logic signed [7:0] cal_s;
  logic signed [17:0] cal_load;
  logic [4:0] s1, s10, m1, m10;

  assign req = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & wb_we_i & ack_ff;
  assign adr = {wb_adr_i, 2'b00};
  assign wr_en = ctrl_ff[rtcac_pkg::CTRL_WR_EN];
  assign timer_on = ctrl_ff[rtcac_pkg::CTRL_TIMER_ON];
  assign cal = ctrl_ff[rtcac_pkg::CTRL_CAL_LSB +: 8];
  assign sec_end = timer_on & tick_en & (pre_ff == 17'h00000);
  // scale signed cal by four pulses a step
  // negative stretches the second, positive shortens it
  assign cal_s = cal;
  assign cal_load = $signed({1'b0, PRE_M1})
                    - ($signed({{10{cal[7]}}, cal})
                       <<< rtcac_pkg::CAL_STEP_SHIFT);
  assign s1 = bcd_inc(time_ms_ff[3:0], rtcac_pkg::BCD_NINE);
  assign s10 = bcd_inc({1'b0, time_ms_ff[6:4]}, rtcac_pkg::BCD_FIVE);
  assign m1 = bcd_inc(time_ms_ff[11:8], rtcac_pkg::BCD_NINE);
  assign m10 = bcd_inc({1'b0, time_ms_ff[14:12]}, rtcac_pkg::BCD_FIVE);
  assign min_end = sec_end & s1[4] & s10[4];

  always_comb begin
    nxt_ack = req & ~ack_ff;
    nxt_rdat = rdat_ff;
    nxt_time_ms = time_ms_ff;
    nxt_alm_md = alm_md_ff;
    nxt_alm_wh = alm_wh_ff;
    nxt_alm_ms = alm_ms_ff;
    nxt_ctrl = ctrl_ff;
    nxt_pre = pre_ff;
    nxt_sec = sec_end;
    nxt_cal = 1'b0;
    if (req & ~ack_ff) begin
      case (adr)
        rtcac_pkg::OFF_TIME_MS: nxt_rdat = {16'h0000, time_ms_ff};
        rtcac_pkg::OFF_ALM_MD: nxt_rdat = {16'h0000, alm_md_ff};
        rtcac_pkg::OFF_ALM_WH: nxt_rdat = {16'h0000, alm_wh_ff};
        rtcac_pkg::OFF_ALM_MS: nxt_rdat = {16'h0000, alm_ms_ff};
        rtcac_pkg::OFF_CTRL: nxt_rdat = {16'h0000, ctrl_ff};
        default: nxt_rdat = 32'h00000000;
      endcase
    end
    // prescaler: one second per PRESCALE ticks
    if (timer_on & tick_en) begin
      if (pre_ff == 17'h00000) begin
        if (s1[4] & s10[4]) begin
          nxt_pre = cal_load[16:0];
          nxt_cal = 1'b1;
        end else begin
          nxt_pre = PRE_M1;
        end
      end else begin
        nxt_pre = pre_ff - 17'h00001;
      end
    end
    if (sec_end) begin
      nxt_time_ms[3:0] = s1[3:0];
      if (s1[4]) begin
        nxt_time_ms[6:4] = s10[2:0];
        if (s10[4]) begin
          nxt_time_ms[11:8] = m1[3:0];
          if (m1[4]) begin
            nxt_time_ms[14:12] = m10[2:0];
          end
        end
      end
    end
    // software write wins over the count in the same cycle
    if (wr_fire) begin
      case (adr)
        rtcac_pkg::OFF_TIME_MS:
          nxt_time_ms = merge(time_ms_ff, wb_dat_i, wb_sel_i,
                              rtcac_pkg::MASK_MS);
        rtcac_pkg::OFF_ALM_MD: begin
          if (wr_en) begin
            nxt_alm_md = merge(alm_md_ff, wb_dat_i, wb_sel_i,
                               rtcac_pkg::MASK_MD);
          end
        end
        rtcac_pkg::OFF_ALM_WH: begin
          if (wr_en) begin
            nxt_alm_wh = merge(alm_wh_ff, wb_dat_i, wb_sel_i,
                               rtcac_pkg::MASK_WH);
          end
        end
        rtcac_pkg::OFF_ALM_MS:
          nxt_alm_ms = merge(alm_ms_ff, wb_dat_i, wb_sel_i,
                             rtcac_pkg::MASK_MS);
        rtcac_pkg::OFF_CTRL:
          nxt_ctrl = merge(ctrl_ff, wb_dat_i, wb_sel_i,
                           rtcac_pkg::MASK_CTRL);
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
      time_ms_ff <= rtcac_pkg::RST_VALUE;
      alm_md_ff <= rtcac_pkg::RST_VALUE;
      alm_wh_ff <= rtcac_pkg::RST_VALUE;
      alm_ms_ff <= rtcac_pkg::RST_VALUE;
      ctrl_ff <= rtcac_pkg::RST_VALUE;
      pre_ff <= PRE_M1;
      sec_ff <= 1'b0;
      cal_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      time_ms_ff <= nxt_time_ms;
      alm_md_ff <= nxt_alm_md;
      alm_wh_ff <= nxt_alm_wh;
      alm_ms_ff <= nxt_alm_ms;
      ctrl_ff <= nxt_ctrl;
      pre_ff <= nxt_pre;
      sec_ff <= nxt_sec;
      cal_ff <= nxt_cal;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign sec_pulse_o = sec_ff;
  assign cal_applied_o = cal_ff;

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_wr_guarded;
    wr_fire && !wr_en &&
      (adr == rtcac_pkg::OFF_ALM_MD || adr == rtcac_pkg::OFF_ALM_WH);
  endsequence

  sequence s_min_wrap;
    min_end ##1 cal_applied_o;
  endsequence

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");

  property p_ack_follows;
    @(posedge clk_i) disable iff (rst_i) req && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("no ack");

  property p_unimpl_zero;
    @(posedge clk_i) disable iff (rst_i)
      ((time_ms_ff & ~rtcac_pkg::MASK_MS) == 16'h0000) &&
      ((alm_ms_ff & ~rtcac_pkg::MASK_MS) == 16'h0000) &&
      ((alm_md_ff & ~rtcac_pkg::MASK_MD) == 16'h0000) &&
      ((alm_wh_ff & ~rtcac_pkg::MASK_WH) == 16'h0000) &&
      (!wb_ack_o || wb_dat_o[31:16] == 16'h0000);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bit set");

  property p_guard;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_guarded |=> $stable(alm_md_ff) && $stable(alm_wh_ff);
  endproperty
  a_guard: assert property (p_guard)
    else $error("alarm changed without write enable");

  property p_bcd_sec;
    @(posedge clk_i) disable iff (rst_i)
      // software may write bad digits, so only a counted step is checked
      sec_pulse_o && !$past(wr_fire) |->
        time_ms_ff[3:0] <= 4'h9 &&
        (time_ms_ff[3:0] != 4'h0 || time_ms_ff[6:4] <= 3'h5);
  endproperty
  a_bcd_sec: assert property (p_bcd_sec)
    else $error("seconds digit out of range");

  property p_bcd_min;
    @(posedge clk_i) disable iff (rst_i)
      sec_pulse_o && !$past(wr_fire) && time_ms_ff[6:0] == 7'h00 |->
        time_ms_ff[11:8] <= 4'h9 &&
        (time_ms_ff[11:8] != 4'h0 || time_ms_ff[14:12] <= 3'h5);
  endproperty
  a_bcd_min: assert property (p_bcd_min)
    else $error("minutes digit out of range");

  property p_cal_load;
    @(posedge clk_i) disable iff (rst_i)
      s_min_wrap |->
        pre_ff == 17'(PRESCALE - 1 - 4 * int'($past(cal_s)));
  endproperty
  a_cal_load: assert property (p_cal_load)
    else $error("calibration reload wrong");

  property p_cal_once;
    @(posedge clk_i) disable iff (rst_i)
      cal_applied_o |-> $past(min_end) && $past(sec_end);
  endproperty
  a_cal_once: assert property (p_cal_once)
    else $error("calibration outside minute boundary");

  property p_sec_pulse;
    @(posedge clk_i) disable iff (rst_i)
      sec_pulse_o |-> $past(timer_on) && $past(tick_en);
  endproperty
  a_sec_pulse: assert property (p_sec_pulse)
    else $error("second pulse without tick");

endmodule

//--- tb/tb_rtcac_core.sv
// self-checking bench for the time, alarm value and calibration core
// assumes the core acks every wishbone request and counts tick_i rising edges
`timescale 1ns/10ps
module tb_rtcac_core;
  // ****************************************
  // stimulus and probes
  // ****************************************
  // short prescale keeps each second near two thousand cycles
  localparam int PRE = 1024;
  localparam logic [15:0] WREN = 16'h2000;
  localparam logic [15:0] TON = 16'h0100;
  typedef struct packed {
    logic we;
    logic [4:0] off;
    logic [15:0] wd;
    logic [3:0] sel;
    logic wren;
    logic [15:0] exp;
  } rtcac_row_t;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [4:2] wb_adr_i = 3'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic tick_i = 1'h0;
  logic tick_run = 1'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sec_pulse_o;
  logic cal_applied_o;
  logic [15:0] rd;
  int run_len = 0;
  int mismatches = 0;
  int n_checks = 0;
  rtcac_row_t rows [12];

  rtcac_core #(.PRESCALE(PRE)) u_rtcac_core (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tick_i(tick_i), .sec_pulse_o(sec_pulse_o),
    .cal_applied_o(cal_applied_o));

  always #50 clk_i = ~clk_i;

  // tick runs at half the clock rate; second length is counted in cycles
  always @(posedge clk_i) begin
    if (tick_run)
      tick_i <= ~tick_i;
    else
      tick_i <= 1'h0;
    if (sec_pulse_o === 1'h1)
      run_len <= 1;
    else
      run_len <= run_len + 1;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk_reg(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_len(input string nm, input int e, input int g);
    n_checks++;
    if (g != e) begin
      mismatches++;
      $display("FAIL %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [4:0] off,
                    input logic [15:0] d, input logic [3:0] sel,
                    output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= off[4:2];
    wb_sel_i <= sel;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20)
      mismatches++;
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask

  task automatic wait_sec(output int n, output logic c);
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (sec_pulse_o !== 1'h1 && k < 4 * PRE);
    n = run_len;
    c = cal_applied_o;
  endtask

  // cal is written with the timer off, as software must
  task automatic cal_run(input logic [7:0] cal);
    int n;
    logic c;
    wb(1'h1, rtcac_pkg::OFF_CTRL, WREN | {8'h00, cal}, 4'h3, rd);
    wb(1'h1, rtcac_pkg::OFF_TIME_MS, 16'h0059, 4'h3, rd);
    wb(1'h1, rtcac_pkg::OFF_CTRL, WREN | TON | {8'h00, cal}, 4'h3, rd);
    wait_sec(n, c);
    chk_reg("minute flag", 16'h0001, {15'h0000, c});
    wb(1'h0, rtcac_pkg::OFF_TIME_MS, 16'h0000, 4'h3, rd);
    chk_reg("time wrap", 16'h0100, rd);
    wait_sec(n, c);
    chk_len("calibrated second", 2 * (PRE - 4 * int'($signed(cal))),
            n);
    chk_reg("flag after", 16'h0000, {15'h0000, c});
    wait_sec(n, c);
    chk_len("plain second", 2 * PRE, n);
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk_i);
    mismatches++;
    print_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rows[0] = '{1'h0, 5'h00, 16'h0000, 4'hF, 1'h0, 16'h0000};
    rows[1] = '{1'h0, 5'h04, 16'h0000, 4'hF, 1'h0, 16'h0000};
    rows[2] = '{1'h1, 5'h00, 16'hFFFF, 4'hF, 1'h0, 16'h7F7F};
    rows[3] = '{1'h1, 5'h0C, 16'hFFFF, 4'hF, 1'h0, 16'h7F7F};
    rows[4] = '{1'h1, 5'h04, 16'hFFFF, 4'hF, 1'h1, 16'h1F3F};
    rows[5] = '{1'h1, 5'h08, 16'hFFFF, 4'hF, 1'h1, 16'h073F};
    rows[6] = '{1'h1, 5'h04, 16'h0000, 4'hF, 1'h0, 16'h1F3F};
    rows[7] = '{1'h1, 5'h08, 16'h0000, 4'hF, 1'h0, 16'h073F};
    rows[8] = '{1'h1, 5'h04, 16'h1234, 4'hF, 1'h1, 16'h1234};
    rows[9] = '{1'h1, 5'h08, 16'h0623, 4'hF, 1'h1, 16'h0623};
    rows[10] = '{1'h1, 5'h00, 16'h1234, 4'h1, 1'h0, 16'h7F34};
    rows[11] = '{1'h1, 5'h14, 16'hFFFF, 4'hF, 1'h1, 16'h0000};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    tick_run <= 1'h1;
    foreach (rows[i]) begin
      wb(1'h1, rtcac_pkg::OFF_CTRL, rows[i].wren ? WREN : 16'h0000,
         4'h3, rd);
      if (rows[i].we)
        wb(1'h1, rows[i].off, rows[i].wd, rows[i].sel, rd);
      wb(1'h0, rows[i].off, 16'h0000, 4'hF, rd);
      chk_reg("register row", rows[i].exp, rd);
    end
    cal_run(8'hFF);
    cal_run(8'h01);
    cal_run(8'h80);
    cal_run(8'h7F);
    // timer off must freeze the seconds
    wb(1'h1, rtcac_pkg::OFF_CTRL, 16'h0000, 4'h3, rd);
    wb(1'h1, rtcac_pkg::OFF_TIME_MS, 16'h0958, 4'h3, rd);
    repeat (2 * PRE + 100) @(posedge clk_i);
    wb(1'h0, rtcac_pkg::OFF_TIME_MS, 16'h0000, 4'h3, rd);
    chk_reg("frozen time", 16'h0958, rd);
    // second reset in mid-run clears the alarm value
    rst_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, rtcac_pkg::OFF_ALM_WH, 16'h0000, 4'h3, rd);
    chk_reg("alarm after reset", 16'h0000, rd);
    print_verdict();
  end
endmodule
